// file: pkg/dbs_regs.vh
// Function
// - All data writes use the single X write port; no other write path.
// - Bit-reversed stepping applies only to X space writes.
// - Dual-operand reads fetch X and Y concurrently; Y path never writes.
// - In dual-operand mode y pointers hit Y only, x pointers X only.
// - Accumulator write back writes over X bus to any data address.
// - X and Y address steps support modulo wrap; Y reads only prefetch.
// - Out-of-space or unimplemented reads return zero; boundary is fixed.
// - Dual-operand pointer crossing into the other space reads zero.
// - Effective addresses are 16-bit byte addresses, 64 KB range.
// - 16-bit data path; shared word decode, one write strobe per byte.
// - Byte read fetches whole word, bit 0 picks byte onto low lane.
// - Y read path carries words only.
// - Byte write strobes only the addressed lane; other byte unchanged.
// - Post-increment steps 1 for bytes, 2 for words and for all x/y pointer accesses.
// - Odd-address word write is not performed; any odd word access raises address error.
// - Misaligned read completes then traps; misaligned write is dropped.
// - Byte load into a pointer register changes only its low byte.
// - Near direct field is 13 bits, reaching 0x0000 to 0x1FFF.
// - Wide direct field is 16 bits, reaching all of X space.
// - Space above near region reachable only indirectly or wide direct.
// - X read path returns combined-space data and dual-operand X data.
// - Dual-operand X reads exclude the Y range; others see full space.
`ifndef DBS_REGS_VH
`define DBS_REGS_VH
`define DBS_ZERO 16'h0000
`define DBS_NEAR_MASK 16'h1FFF
`define DBS_MEM_TOP 16'h2FFF
`define DBS_Y_BASE 16'h1800
`define DBS_Y_END 16'h27FF
`define DBS_RAM_WORDS 6144
`define DBS_RAM_AW 13
`define DBS_MODE_NEAR 2'h0
`define DBS_MODE_WIDE 2'h1
`define DBS_MODE_SRC 2'h2
`define DBS_MODE_MACP 2'h3
`define DBS_STEP_BYTE 16'h0001
`define DBS_STEP_WORD 16'h0002
`define DBS_PTR_RST 16'h0000
`endif

// file: logic/dbs_agu.v
`timescale 1ns/100ps
`include "dbs_regs.vh"
// Post-modify step for one pointer: linear, modulo or reverse-carry.
module dbs_agu (
  input wire [15:0] i_ptr,
  input wire i_byte,
  input wire i_mod_en,
  input wire [15:0] i_mod_start,
  input wire [15:0] i_mod_end,
  input wire i_brev_en,
  input wire [15:0] i_brev_mod,
  output reg [15:0] o_next
);
  wire [15:0] rev_ptr;
  wire [15:0] rev_mod;
  wire [15:0] rev_sum;
  wire [15:0] brev_next;
  wire [15:0] step;
  wire [15:0] lin_next;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_rev
      assign rev_ptr[gi] = i_ptr[15 - gi];
      assign rev_mod[gi] = i_brev_mod[15 - gi];
      assign brev_next[gi] = rev_sum[15 - gi];
    end
  endgenerate

  // Carry runs from the top bit downward, giving FFT-order addresses
  assign rev_sum = rev_ptr + rev_mod;
  assign step = i_byte ? `DBS_STEP_BYTE : `DBS_STEP_WORD;
  assign lin_next = i_ptr + step;

  always @* begin
    if (i_brev_en) begin
      o_next = brev_next;
    end else if (i_mod_en && (i_ptr == i_mod_end ||
                              lin_next > i_mod_end)) begin
      o_next = i_mod_start;
    end else begin
      o_next = lin_next;
    end
  end
endmodule

// file: logic/dbs_ram.v
`timescale 1ns/100ps
`include "dbs_regs.vh"
// Data array: one byte-strobed write port, two word read ports.
module dbs_ram (
  input wire i_core_clk,
  input wire [`DBS_RAM_AW-1:0] i_wr_addr,
  input wire [1:0] i_wr_strb,
  input wire [15:0] i_wr_data,
  input wire [`DBS_RAM_AW-1:0] i_xr_addr,
  output wire [15:0] o_xr_data,
  input wire [`DBS_RAM_AW-1:0] i_yr_addr,
  output wire [15:0] o_yr_data
);
  reg [15:0] mem [0:`DBS_RAM_WORDS-1];

  // The only write port of the array: the X write bus
  always @(posedge i_core_clk) begin
    if (i_wr_strb[0]) begin
      mem[i_wr_addr][7:0] <= i_wr_data[7:0];
    end
    if (i_wr_strb[1]) begin
      mem[i_wr_addr][15:8] <= i_wr_data[15:8];
    end
  end

  // Shared word decode for both lanes; registered by the caller
  assign o_xr_data = mem[i_xr_addr];
  assign o_yr_data = mem[i_yr_addr];
endmodule

// file: logic/dbs_access.v
`timescale 1ns/100ps
`include "dbs_regs.vh"
module dbs_access (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_mac,
  input wire i_x_req,
  input wire i_x_we,
  input wire i_x_byte,
  input wire [1:0] i_x_mode,
  input wire [15:0] i_x_direct,
  input wire i_x_ptr_sel,
  input wire i_x_postinc,
  input wire [15:0] i_x_wdata,
  input wire [15:0] i_src_ptr,
  input wire i_y_req,
  input wire i_y_ptr_sel,
  input wire i_y_postinc,
  input wire i_xmod_en,
  input wire [15:0] i_xmod_start,
  input wire [15:0] i_xmod_end,
  input wire i_ymod_en,
  input wire [15:0] i_ymod_start,
  input wire [15:0] i_ymod_end,
  input wire i_brev_en,
  input wire [15:0] i_brev_mod,
  input wire i_ptr_wr,
  input wire [1:0] i_ptr_idx,
  input wire i_ptr_byte,
  input wire [15:0] i_ptr_wdata,
  output reg [15:0] o_x_rdata,
  output reg o_x_rvalid,
  output reg [15:0] o_y_rdata,
  output reg o_y_rvalid,
  output reg o_addr_err,
  output reg o_addr_err_wr,
  output reg [15:0] o_src_ptr_next,
  output reg o_src_ptr_upd,
  output wire [15:0] o_x_pointer_a,
  output wire [15:0] o_x_pointer_b,
  output wire [15:0] o_y_pointer_a,
  output wire [15:0] o_y_pointer_b
);
  // Pointer file: 0,1 = x_pointer_a/b, 2,3 = y_pointer_a/b
  reg [15:0] ptr_q [0:3];
  reg [15:0] x_ea;
  wire [15:0] x_ptr_now;
  wire [15:0] y_ea;
  wire [15:0] x_next;
  wire [15:0] y_next;
  wire [15:0] xr_word;
  wire [15:0] yr_word;
  wire x_impl;
  wire x_in_y;
  wire x_mis;
  wire x_rd;
  wire x_rd_ok;
  wire x_wr;
  wire x_upd_macp;
  wire x_upd_src;
  wire y_rd;
  wire y_ok;
  wire y_mis;
  wire y_upd;
  wire [1:0] wr_strb;
  wire [15:0] wr_lane;
  wire [`DBS_RAM_AW-1:0] x_word;
  wire [`DBS_RAM_AW-1:0] y_word;

  assign x_ptr_now = ptr_q[{1'b0, i_x_ptr_sel}];
  assign y_ea = ptr_q[{1'b1, i_y_ptr_sel}];

  // Effective address: all forms yield a 16-bit byte address
  always @* begin
    case (i_x_mode)
      `DBS_MODE_NEAR: x_ea = i_x_direct & `DBS_NEAR_MASK;
      `DBS_MODE_WIDE: x_ea = i_x_direct;
      `DBS_MODE_SRC: x_ea = i_src_ptr;
      `DBS_MODE_MACP: x_ea = x_ptr_now;
      default: x_ea = `DBS_ZERO;
    endcase
  end

  assign x_impl = (x_ea <= `DBS_MEM_TOP);
  assign x_in_y = (x_ea >= `DBS_Y_BASE) && (x_ea <= `DBS_Y_END);
  assign x_mis = !i_x_byte && x_ea[0];
  assign x_rd = i_x_req && !i_x_we;
  // Dual-operand X reads must not see the Y block
  assign x_rd_ok = x_impl && !(i_mac && x_in_y);
  // Writes see the combined space, so write back reaches any address
  assign x_wr = i_x_req && i_x_we && !x_mis && x_impl;

  // Y path is read-only, word-only, and only during dual-operand work
  assign y_rd = i_y_req && i_mac;
  assign y_ok = (y_ea >= `DBS_Y_BASE) && (y_ea <= `DBS_Y_END);
  assign y_mis = y_ea[0];

  assign x_word = x_ea[`DBS_RAM_AW:1];
  assign y_word = y_ea[`DBS_RAM_AW:1];

  // Byte writes replicate the byte on both lanes and strobe one
  assign wr_lane = i_x_byte ? {i_x_wdata[7:0], i_x_wdata[7:0]} :
                   i_x_wdata;
  assign wr_strb = !x_wr ? 2'h0 :
                   !i_x_byte ? 2'h3 :
                   (x_ea[0] ? 2'h2 : 2'h1);

  dbs_ram u_ram (
    .i_core_clk(i_core_clk),
    .i_wr_addr(x_word),
    .i_wr_strb(wr_strb),
    .i_wr_data(wr_lane),
    .i_xr_addr(x_word),
    .o_xr_data(xr_word),
    .i_yr_addr(y_word),
    .o_yr_data(yr_word)
  );

  // Reverse-carry stepping only on X writes
  dbs_agu u_x_agu (
    .i_ptr(x_ea),
    .i_byte(i_x_byte && (i_x_mode != `DBS_MODE_MACP)),
    .i_mod_en(i_xmod_en),
    .i_mod_start(i_xmod_start),
    .i_mod_end(i_xmod_end),
    .i_brev_en(i_brev_en && i_x_we),
    .i_brev_mod(i_brev_mod),
    .o_next(x_next)
  );

  dbs_agu u_y_agu (
    .i_ptr(y_ea),
    .i_byte(1'b0),
    .i_mod_en(i_ymod_en),
    .i_mod_start(i_ymod_start),
    .i_mod_end(i_ymod_end),
    .i_brev_en(1'b0),
    .i_brev_mod(`DBS_ZERO),
    .o_next(y_next)
  );

  assign x_upd_macp = i_x_req && i_x_postinc &&
                      (i_x_mode == `DBS_MODE_MACP);
  assign x_upd_src = i_x_req && i_x_postinc &&
                     (i_x_mode == `DBS_MODE_SRC);
  assign y_upd = y_rd && i_y_postinc;

  // A software load wins over a post-modify in the same cycle
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1) begin : g_ptr
      wire ld_hit = ({30'h0, i_ptr_idx} == gp);
      wire odd_entry = (gp % 2 == 1);
      always @(posedge i_core_clk) begin
        if (i_srst) begin
          ptr_q[gp] <= `DBS_PTR_RST;
        end else if (i_ptr_wr && ld_hit) begin
          if (i_ptr_byte) begin
            ptr_q[gp] <= {ptr_q[gp][15:8], i_ptr_wdata[7:0]};
          end else begin
            ptr_q[gp] <= i_ptr_wdata;
          end
        end else if (gp < 2 && x_upd_macp && i_x_ptr_sel == odd_entry) begin
          ptr_q[gp] <= x_next;
        end else if (gp >= 2 && y_upd && i_y_ptr_sel == odd_entry) begin
          ptr_q[gp] <= y_next;
        end
      end
    end
  endgenerate

  assign o_x_pointer_a = ptr_q[0];
  assign o_x_pointer_b = ptr_q[1];
  assign o_y_pointer_a = ptr_q[2];
  assign o_y_pointer_b = ptr_q[3];

  // Answer flags and the Y word leave on the edge after the request
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_x_rvalid <= 1'b0;
      o_y_rvalid <= 1'b0;
      o_y_rdata <= `DBS_ZERO;
      o_addr_err <= 1'b0;
      o_addr_err_wr <= 1'b0;
      o_src_ptr_next <= `DBS_ZERO;
      o_src_ptr_upd <= 1'b0;
    end else begin
      // A misaligned read still completes; only the trap follows
      o_x_rvalid <= x_rd;
      o_y_rvalid <= y_rd;
      o_y_rdata <= (y_rd && y_ok) ? yr_word : `DBS_ZERO;
      o_addr_err <= (i_x_req && x_mis) || (y_rd && y_mis);
      o_addr_err_wr <= i_x_req && i_x_we && x_mis;
      o_src_ptr_upd <= x_upd_src;
      if (x_upd_src) begin
        o_src_ptr_next <= x_next;
      end
    end
  end

  // Read data is captured in the request cycle; bytes land on lane 0
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_x_rdata <= `DBS_ZERO;
    end else if (x_rd) begin
      if (!x_rd_ok) begin
        o_x_rdata <= `DBS_ZERO;
      end else if (i_x_byte) begin
        o_x_rdata <= {8'h00, x_ea[0] ? xr_word[15:8] :
                      xr_word[7:0]};
      end else begin
        o_x_rdata <= xr_word;
      end
    end
  end
endmodule

// file: bench/dbs_core_model.sv
`timescale 1ns/100ps
// Core exception side: counts address error traps it would take
module dbs_core_model (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_addr_err,
  output logic [7:0] o_trap_cnt
);
  always @(posedge i_core_clk) begin
    if (i_srst) o_trap_cnt <= 8'h00;
    else if (i_addr_err) o_trap_cnt <= o_trap_cnt + 8'h01;
  end
endmodule

// file: bench/dbs_access_sva.sv
`timescale 1ns/100ps
`include "dbs_regs.vh"
module dbs_access_chk (
  input wire i_core_clk, input wire i_srst, input wire i_mac,
  input wire i_x_req, input wire i_x_we, input wire i_x_byte,
  input wire [1:0] i_x_mode, input wire [15:0] i_x_direct,
  input wire i_y_req, input wire i_ptr_wr, input wire [1:0] i_ptr_idx,
  input wire i_ptr_byte, input wire [15:0] i_ptr_wdata,
  input wire [15:0] o_x_rdata, input wire o_x_rvalid,
  input wire [15:0] o_y_rdata, input wire o_y_rvalid,
  input wire o_addr_err, input wire o_addr_err_wr,
  input wire [15:0] o_y_pointer_a
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  wire xrd = i_x_req && !i_x_we;
  wire wide = i_x_mode == `DBS_MODE_WIDE;
  a_xrd_valid: assert property (xrd |=> o_x_rvalid)
    else $error("X read gave no valid");
  a_xrd_only: assert property (!xrd |=> !o_x_rvalid)
    else $error("X valid without read");
  a_y_valid: assert property (i_y_req && i_mac |=> o_y_rvalid)
    else $error("Y read gave no valid");
  a_y_nomac: assert property (!(i_y_req && i_mac) |=>
    !o_y_rvalid && o_y_rdata == 16'h0000)
    else $error("Y answered outside dual read");
  a_err_dir: assert property (i_x_req && !i_x_byte && wide &&
    i_x_direct[0] |=> o_addr_err && o_addr_err_wr == $past(i_x_we))
    else $error("Misaligned word without error");
  a_byte_low: assert property (xrd && i_x_byte |=>
    o_x_rdata[15:8] == 8'h00)
    else $error("Byte read high lane not zero");
  a_unimpl_zero: assert property (xrd && wide &&
    i_x_direct > `DBS_MEM_TOP |=> o_x_rdata == 16'h0000)
    else $error("Unimplemented read not zero");
  a_mac_xzero: assert property (xrd && i_mac && wide &&
    i_x_direct >= `DBS_Y_BASE && i_x_direct <= `DBS_Y_END
    |=> o_x_rdata == 16'h0000)
    else $error("Dual X read into Y not zero");
  a_ptr_load: assert property (i_ptr_wr && !i_ptr_byte &&
    i_ptr_idx == 2'h2 |=> o_y_pointer_a == $past(i_ptr_wdata))
    else $error("Y pointer load lost");
endmodule
bind dbs_access dbs_access_chk i_dbs_access_chk (.i_core_clk, .i_srst,
  .i_mac, .i_x_req, .i_x_we, .i_x_byte, .i_x_mode, .i_x_direct, .i_y_req,
  .i_ptr_wr, .i_ptr_idx, .i_ptr_byte, .i_ptr_wdata, .o_x_rdata, .o_x_rvalid,
  .o_y_rdata, .o_y_rvalid, .o_addr_err, .o_addr_err_wr, .o_y_pointer_a);

// file: bench/dbs_access_test.sv
`timescale 1ns/100ps
`include "dbs_regs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module dbs_access_test;
  logic i_core_clk = 0, i_srst = 1, i_mac = 0, i_x_req = 0, i_x_we = 0;
  logic i_x_byte = 0, i_x_ptr_sel = 0, i_x_postinc = 0, i_y_req = 0;
  logic i_y_ptr_sel = 0, i_y_postinc = 0, i_xmod_en = 0, i_ymod_en = 0;
  logic i_brev_en = 0, i_ptr_wr = 0, i_ptr_byte = 0;
  logic [1:0] i_x_mode = 0, i_ptr_idx = 0;
  logic [15:0] i_x_direct = 0, i_x_wdata = 0, i_src_ptr = 0, i_ptr_wdata = 0;
  logic [15:0] i_xmod_start = 0, i_xmod_end = 0, i_ymod_start = 0;
  logic [15:0] i_ymod_end = 0, i_brev_mod = 0;
  wire [15:0] o_x_rdata, o_y_rdata, o_src_ptr_next, o_x_pointer_a;
  wire [15:0] o_x_pointer_b, o_y_pointer_a, o_y_pointer_b;
  wire o_x_rvalid, o_y_rvalid, o_addr_err, o_addr_err_wr, o_src_ptr_upd;
  wire [7:0] trap_cnt;
  int n_errors = 0, compares = 0;
  dbs_access i_dbs_access (.i_core_clk, .i_srst, .i_mac, .i_x_req, .i_x_we,
    .i_x_byte, .i_x_mode, .i_x_direct, .i_x_ptr_sel, .i_x_postinc,
    .i_x_wdata, .i_src_ptr, .i_y_req, .i_y_ptr_sel, .i_y_postinc, .i_xmod_en,
    .i_xmod_start, .i_xmod_end, .i_ymod_en, .i_ymod_start, .i_ymod_end,
    .i_brev_en, .i_brev_mod, .i_ptr_wr, .i_ptr_idx, .i_ptr_byte,
    .i_ptr_wdata, .o_x_rdata, .o_x_rvalid, .o_y_rdata, .o_y_rvalid,
    .o_addr_err, .o_addr_err_wr, .o_src_ptr_next, .o_src_ptr_upd,
    .o_x_pointer_a, .o_x_pointer_b, .o_y_pointer_a, .o_y_pointer_b);
  dbs_core_model i_dbs_core_model (.i_core_clk, .i_srst,
    .i_addr_err(o_addr_err), .o_trap_cnt(trap_cnt));
  initial forever #2.5 i_core_clk = ~i_core_clk;
  // One request cycle; outputs of the answer are settled on return
  task xop(input logic m, we, bt, input logic [1:0] md,
           input logic [15:0] a, d);
    @(posedge i_core_clk); #1;
    {i_mac, i_x_req, i_x_we, i_x_byte, i_x_mode} = {m, 1'b1, we, bt, md};
    {i_x_direct, i_src_ptr, i_x_wdata} = {a, a, d};
    @(posedge i_core_clk); #1;
    // Dual-operand mode ends with the request so Y prefetch stays one shot
    {i_mac, i_x_req} = 2'b00;
  endtask
  task rd(input logic m, input logic [1:0] md, input logic [15:0] a, e);
    xop(m, 0, 0, md, a, 16'h0000);
    `CHK(o_x_rvalid, 1'b1)
    `CHK(o_x_rdata, e)
  endtask
  task ptld(input logic [1:0] idx, input logic bt, input logic [15:0] d);
    @(posedge i_core_clk); #1;
    {i_ptr_wr, i_ptr_idx, i_ptr_byte, i_ptr_wdata} = {1'b1, idx, bt, d};
    @(posedge i_core_clk); #1;
    i_ptr_wr = 0;
  endtask
  task t_word_byte;
    xop(0, 1, 0, `DBS_MODE_WIDE, 16'h0100, 16'hA55A);
    rd(0, `DBS_MODE_WIDE, 16'h0100, 16'hA55A);
    rd(0, `DBS_MODE_NEAR, 16'h2100, 16'hA55A);
    xop(0, 1, 1, `DBS_MODE_WIDE, 16'h0101, 16'h003C);
    rd(0, `DBS_MODE_WIDE, 16'h0100, 16'h3C5A);
    xop(0, 0, 1, `DBS_MODE_WIDE, 16'h0100, 16'h0000);
    `CHK(o_x_rdata, 16'h005A)
    xop(0, 0, 1, `DBS_MODE_WIDE, 16'h0101, 16'h0000);
    `CHK(o_x_rdata, 16'h003C)
  endtask
  task t_space;
    xop(0, 1, 0, `DBS_MODE_WIDE, 16'h1800, 16'h1234);
    rd(0, `DBS_MODE_WIDE, 16'h1800, 16'h1234);
    rd(1, `DBS_MODE_WIDE, 16'h1800, 16'h0000);
    rd(0, `DBS_MODE_WIDE, 16'h3000, 16'h0000);
  endtask
  task t_misalign;
    xop(0, 1, 0, `DBS_MODE_WIDE, 16'h0101, 16'hFFFF);
    `CHK({o_addr_err, o_addr_err_wr}, 2'b11)
    rd(0, `DBS_MODE_WIDE, 16'h0100, 16'h3C5A);
    rd(0, `DBS_MODE_WIDE, 16'h0101, 16'h3C5A);
    `CHK({o_addr_err, o_addr_err_wr}, 2'b10)
  endtask
  task t_dual;
    {i_ymod_en, i_ymod_start, i_ymod_end} = {1'b1, 16'h1800, 16'h1803};
    ptld(2'h0, 0, 16'h0100);
    ptld(2'h2, 0, 16'h1800);
    {i_y_req, i_y_postinc} = 2'b11;
    rd(1, `DBS_MODE_MACP, 16'h0000, 16'h3C5A);
    `CHK(o_y_rdata, 16'h1234)
    `CHK(o_y_pointer_a, 16'h1802)
    xop(1, 0, 0, `DBS_MODE_MACP, 16'h0000, 16'h0000);
    `CHK(o_y_pointer_a, 16'h1800)
    ptld(2'h3, 0, 16'h0100);
    i_y_ptr_sel = 1;
    xop(1, 0, 0, `DBS_MODE_MACP, 16'h0000, 16'h0000);
    `CHK({o_y_rvalid, o_y_rdata}, 17'h10000)
    `CHK(o_y_pointer_b, 16'h0102)
    xop(0, 0, 0, `DBS_MODE_MACP, 16'h0000, 16'h0000);
    `CHK(o_y_rvalid, 1'b0)
    i_y_req = 0;
  endtask
  task t_ptr;
    ptld(2'h1, 0, 16'h1234);
    ptld(2'h1, 1, 16'h00AB);
    `CHK(o_x_pointer_b, 16'h12AB)
    i_x_postinc = 1;
    rd(0, `DBS_MODE_SRC, 16'h0100, 16'h3C5A);
    `CHK({o_src_ptr_upd, o_src_ptr_next}, 17'h10102)
    xop(0, 0, 1, `DBS_MODE_SRC, 16'h0100, 16'h0000);
    `CHK(o_src_ptr_next, 16'h0101)
    // Reverse carry of 0x0100 by 0x0004 lands on 0x0104, the linear read step then on 0x0106
    {i_brev_en, i_brev_mod} = {1'b1, 16'h0004};
    xop(0, 1, 0, `DBS_MODE_MACP, 16'h0000, 16'h0000);
    `CHK(o_x_pointer_a, 16'h0104)
    xop(0, 0, 0, `DBS_MODE_MACP, 16'h0000, 16'h0000);
    `CHK(o_x_pointer_a, 16'h0106)
  endtask
  // Mid-run reset: state clears, the array keeps its contents
  task t_reset;
    @(posedge i_core_clk); #1;
    i_srst = 1;
    @(posedge i_core_clk); #1;
    i_srst = 0;
    `CHK({o_x_pointer_a, o_x_pointer_b}, 32'h00000000)
    `CHK({o_y_pointer_a, o_y_pointer_b}, 32'h00000000)
    `CHK({o_x_rvalid, o_y_rvalid, o_addr_err, o_src_ptr_upd}, 4'h0)
    `CHK({o_x_rdata, o_y_rdata, o_src_ptr_next}, 48'h000000000000)
    `CHK(trap_cnt, 8'h00)
    rd(0, `DBS_MODE_WIDE, 16'h0100, 16'h0000);
  endtask
  task wrap_up;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge i_core_clk);
    #1 i_srst = 0;
    `CHK(o_y_pointer_a, `DBS_PTR_RST)
    t_word_byte;
    t_space;
    t_misalign;
    t_dual;
    t_ptr;
    `CHK(trap_cnt, 8'h02)
    t_reset;
    wrap_up;
  end
endmodule
